// >>> hw/adc_rate_defines.vh
// timing and format constants for the converter rate and sync control
`ifndef ADC_RATE_DEFINES_VH
`define ADC_RATE_DEFINES_VH

// internal oscillator nominal rate in hz and the notch it gives
`define OSC_HZ             153600
`define NOTCH60_HZ         60
`define NOTCH50_HZ         50
// system clock rate in hz
`define MCLK_HZ            50000000
// rate-pin clocks per conversion result
`define CLKS_PER_CONV      20480
`define OSR                256
// rate-pin clocks per modulator sample: 2560 per notch period over 256 samples
`define CLKS_PER_SAMPLE    8'h0a
// result word length in serial clocks
`define RESULT_BITS        24
// internal oscillator half period in system clocks, derived from the rates
`define OSC60_HALF         (`MCLK_HZ / (2 * `OSC_HZ))
// divide before multiplying so the product stays inside 32 bits
`define OSC50_HALF         (`MCLK_HZ / `NOTCH50_HZ * `NOTCH60_HZ / (2 * `OSC_HZ))
// cycles the notch pin may sit still before it counts as a level, not a clock
`define EXT_IDLE_CYC       10'h3e8

`endif

// >>> hw/edge_sync.v
// two-stage synchroniser with rise and fall pulses for one pin
`timescale 1ns/10ps
module edge_sync (
  // clock and reset
  input  wire mclk_i,
  input  wire nrst_i,
  // pin side
  input  wire pin_i,
  // synchronised level and edges
  output reg  level_o,
  output wire rise_o,
  output wire fall_o
);

  reg meta_q;
  reg prev_q;

  // first stage is read by the second stage only
  always @(posedge mclk_i) begin
    if (!nrst_i) begin
      meta_q  <= 1'b1;
      level_o <= 1'b1;
      prev_q  <= 1'b1;
    end else begin
      meta_q  <= pin_i;
      level_o <= meta_q;
      prev_q  <= level_o;
    end
  end

  assign rise_o = level_o & ~prev_q;
  assign fall_o = ~level_o & prev_q;

endmodule // edge_sync

// >>> hw/adc_rate_and_sync_control.v
// conversion timing, chip-select sync and read-out for the delta-sigma converter
//
// Summary of operation
// RL1: notch pin low 60 hz, high 50 hz
// RL2: internal oscillator nominally 153.6 khz
// RL3: external clock: one result per 20480 cycles
// RL4: modulator samples at 256 times notch
// RL5: chip-select rising edge starts a conversion
// RL6: 24th serial falling edge autostarts conversion
// RL7: host gives at most 23 clocks to avoid
// RL8: serial clock may have any timing
// RL9: shared chip select gives simultaneous sampling
// RL10: separate chip selects spaced evenly interleave
// RL11: serial clock and data lines may be shared
// RL12: common external clock aligns sampling instants
// RL13: each conversion uses only its own period
// RL14: host may return pin low for 60 hz
// RL15: result bit changes on serial falling edge
// RL16: data out released while chip select high
// RL17: short read waits for next chip-select rise
`timescale 1ns/10ps
`include "adc_rate_defines.vh"
module adc_rate_and_sync_control #(
  parameter CONV_CLKS = `CLKS_PER_CONV,
  parameter OSR_N     = `OSR,
  parameter NBITS     = `RESULT_BITS
) (
  // clock and reset
  input  wire        mclk_i,
  input  wire        nrst_i,
  // notch select or external conversion clock
  input  wire        notch_select_clock_pin_i,
  // serial host side
  input  wire        cs_n_i,
  input  wire        sck_i,
  output reg         sdo_o,
  output reg         sdo_oe_o,
  // converter core side
  input  wire [23:0] result_i,
  output reg         mod_sample_o,
  output reg         conv_busy_o,
  output reg         conv_done_o,
  output reg         ext_clk_mode_o,
  output reg         notch50_o
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  wire f_lvl, f_rise, f_fall;
  wire cs_lvl, cs_rise, cs_fall;
  wire sck_fall;

  edge_sync u_f (
    .mclk_i (mclk_i),
    .nrst_i (nrst_i),
    .pin_i  (notch_select_clock_pin_i),
    .level_o(f_lvl),
    .rise_o (f_rise),
    .fall_o (f_fall)
  );
  edge_sync u_cs (
    .mclk_i (mclk_i),
    .nrst_i (nrst_i),
    .pin_i  (cs_n_i),
    .level_o(cs_lvl),
    .rise_o (cs_rise),
    .fall_o (cs_fall)
  );
  edge_sync u_sck (
    .mclk_i (mclk_i),
    .nrst_i (nrst_i),
    .pin_i  (sck_i),
    .level_o(),
    .rise_o (),
    .fall_o (sck_fall)
  );

  // ----------------------------------------------------------------
  // rate source: level selects internal notch, toggling means external clock
  // ----------------------------------------------------------------
  localparam [9:0]   IDLE_CYC   = `EXT_IDLE_CYC;
  localparam [7:0]   SAMPLE_DIV = `CLKS_PER_SAMPLE;
  localparam integer HALF60_N   = `OSC60_HALF;
  localparam integer HALF50_N   = `OSC50_HALF;
  localparam [15:0]  HALF60     = HALF60_N[15:0];
  localparam [15:0]  HALF50     = HALF50_N[15:0];

  reg  [9:0]  idle_q;
  reg  [15:0] osc_cnt_q;
  reg         osc_q;
  wire [15:0] half = f_lvl ? HALF50 : HALF60;     // RL1
  wire        int_tick;
  wire        ext_mode = (idle_q != 10'h000);

  // the notch synchroniser leaves reset at one, so a low pin would show a
  // false fall; pin edges count only once the chain holds the real level
  reg  [1:0]  settle_q;
  wire        f_edge = (f_rise | f_fall) & (settle_q == 2'h3);

  always @(posedge mclk_i) begin
    if (!nrst_i) begin
      settle_q <= 2'h0;
    end else if (settle_q != 2'h3) begin
      settle_q <= settle_q + 2'h1;
    end
  end

  // an edge on the pin restarts the idle window; a still pin means a level
  always @(posedge mclk_i) begin
    if (!nrst_i) begin
      idle_q <= 10'h000;
    end else if (f_edge) begin
      idle_q <= IDLE_CYC;
    end else if (idle_q != 10'h000) begin
      idle_q <= idle_q - 10'h001;
    end
  end

  // internal oscillator divided from the system clock
  always @(posedge mclk_i) begin
    if (!nrst_i) begin
      osc_cnt_q <= 16'h0000;
      osc_q     <= 1'b0;
    end else if (osc_cnt_q + 16'h0001 >= half) begin
      osc_cnt_q <= 16'h0000;
      osc_q     <= ~osc_q;                         // RL2
    end else begin
      osc_cnt_q <= osc_cnt_q + 16'h0001;
    end
  end
  assign int_tick = (osc_cnt_q + 16'h0001 >= half) & ~osc_q;

  // one modulator clock: external rising edge or internal oscillator tick
  wire mod_tick = ext_mode ? f_rise : int_tick;   // RL3 RL12

  // ----------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_CONV = 2'h1;
  localparam [1:0] ST_DONE = 2'h2;

  reg  [1:0]  state_q;
  reg  [14:0] conv_cnt_q;
  reg  [7:0]  osr_cnt_q;
  reg  [4:0]  bit_cnt_q;
  reg  [23:0] shift_q;
  wire        auto_start = (state_q == ST_DONE) & ~cs_lvl & sck_fall
                           & (bit_cnt_q == NBITS - 1);          // RL6
  wire        start = cs_rise | auto_start;                     // RL5
  wire        last_clk = (conv_cnt_q == CONV_CLKS - 1);
  // the modulator samples once per ten rate clocks, 256 times per notch period
  wire        mod_sample = (state_q == ST_CONV) & mod_tick & ~cs_rise
                           & (osr_cnt_q == SAMPLE_DIV - 8'h01);   // RL4

  // a fresh start clears the conversion and sample counts so no period leaks into the next
  always @(posedge mclk_i) begin
    if (!nrst_i) begin
      state_q    <= ST_IDLE;
      conv_cnt_q <= 15'h0000;
      osr_cnt_q  <= 8'h00;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start) begin
            state_q    <= ST_CONV;
            conv_cnt_q <= 15'h0000;                    // RL13
            osr_cnt_q  <= 8'h00;
          end
        end
        ST_CONV: begin
          if (cs_rise) begin
            conv_cnt_q <= 15'h0000;                    // RL5 RL9 RL10
            osr_cnt_q  <= 8'h00;
          end else if (mod_tick) begin
            if (last_clk) begin
              state_q <= ST_DONE;
            end
            conv_cnt_q <= conv_cnt_q + 15'h0001;
            if (osr_cnt_q == SAMPLE_DIV - 8'h01) begin
              osr_cnt_q <= 8'h00;
            end else begin
              osr_cnt_q <= osr_cnt_q + 8'h01;
            end
          end
        end
        ST_DONE: begin
          // short read leaves us here until chip select rises
          if (start) begin
            state_q    <= ST_CONV;                     // RL17
            conv_cnt_q <= 15'h0000;
            osr_cnt_q  <= 8'h00;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read-out shifter: counts serial falling edges only, so pace is free
  // ----------------------------------------------------------------
  always @(posedge mclk_i) begin
    if (!nrst_i) begin
      bit_cnt_q <= 5'h00;
      shift_q   <= 24'h000000;
    end else if (state_q == ST_CONV && mod_tick && last_clk) begin
      shift_q   <= result_i;
      bit_cnt_q <= 5'h00;
    end else if (cs_fall) begin
      bit_cnt_q <= 5'h00;
    end else if (state_q == ST_DONE && !cs_lvl && sck_fall) begin
      shift_q   <= {shift_q[22:0], 1'b0};            // RL15 RL8
      bit_cnt_q <= bit_cnt_q + 5'h01;
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  always @(posedge mclk_i) begin
    if (!nrst_i) begin
      sdo_o          <= 1'b0;
      sdo_oe_o       <= 1'b0;
      mod_sample_o   <= 1'b0;
      conv_busy_o    <= 1'b0;
      conv_done_o    <= 1'b0;
      ext_clk_mode_o <= 1'b0;
      notch50_o      <= 1'b0;
    end else begin
      sdo_o          <= shift_q[23];
      sdo_oe_o       <= ~cs_lvl;                    // RL16 RL11
      // one pulse per modulator sample, never on a restart cycle
      mod_sample_o   <= mod_sample;                 // RL4
      conv_busy_o    <= (state_q == ST_CONV);
      conv_done_o    <= (state_q == ST_CONV) & mod_tick & last_clk & ~cs_rise;
      ext_clk_mode_o <= ext_mode;                   // RL14
      notch50_o      <= ~ext_mode & f_lvl;          // RL1
    end
  end

endmodule // adc_rate_and_sync_control

// >>> sim/adc_rate_and_sync_control_assertions.sv
// concurrent checks on the rate and sync control ports
`timescale 1ns/10ps
module adc_rate_and_sync_control_assertions (
  // clock and pins
  input wire mclk_i,
  input wire nrst_i,
  input wire notch_select_clock_pin_i,
  input wire cs_n_i,
  // observed outputs
  input wire sdo_oe_o,
  input wire mod_sample_o,
  input wire conv_busy_o,
  input wire conv_done_o,
  input wire ext_clk_mode_o
);
  reg        pin_q;
  reg [10:0] idle_q;
  // cycles the notch pin has sat still, saturating
  always @(posedge mclk_i) begin
    pin_q  <= notch_select_clock_pin_i;
    idle_q <= (!nrst_i || pin_q != notch_select_clock_pin_i) ? 11'h0 :
              (idle_q == 11'h7ff) ? idle_q : idle_q + 11'h1;
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  oe_off_cs_a: assert property (cs_n_i [*5] |-> !sdo_oe_o) else $error("sdo driven");
  oe_on_cs_a: assert property (!cs_n_i [*5] |-> sdo_oe_o) else $error("sdo not driven");
  cs_start_a: assert property ($rose(cs_n_i) |-> ##[1:6] conv_busy_o) else $error("no start");
  done_pulse_a: assert property (conv_done_o |=> !conv_done_o) else $error("long done");
  busy_hold_a: assert property ($fell(conv_busy_o) |-> conv_done_o || $past(conv_done_o))
    else $error("busy dropped early");
  done_after_a: assert property (conv_done_o |-> $past(conv_busy_o)) else $error("stray done");
  sample_conv_a: assert property (mod_sample_o |-> conv_busy_o || conv_done_o)
    else $error("idle sample");
  ext_idle_a: assert property (idle_q > 11'h44c |-> !ext_clk_mode_o) else $error("ext stuck");
  cover property (conv_done_o);
  cover property (ext_clk_mode_o && conv_done_o);
  cover property (!cs_n_i && $rose(conv_busy_o));
endmodule // adc_rate_and_sync_control_assertions
bind adc_rate_and_sync_control adc_rate_and_sync_control_assertions
  adc_rate_and_sync_control_assertions_i (.mclk_i, .nrst_i, .notch_select_clock_pin_i,
  .cs_n_i, .sdo_oe_o, .mod_sample_o, .conv_busy_o, .conv_done_o, .ext_clk_mode_o);

// >>> sim/host_model.sv
// serial host model driving chip select and serial clock
`timescale 1ns/10ps
module host_model (
  // clock and data in
  input  wire mclk_i,
  input  wire sdo_i,
  input  wire sdo_oe_i,
  // host outputs
  output reg  cs_n_o,
  output reg  sck_o
);
  reg  [23:0] data_q;
  // a released line never shows the last bit
  wire        line = sdo_oe_i ? sdo_i : ~sdo_i;
  initial begin
    cs_n_o = 1'b1;
    sck_o  = 1'b1;
    data_q = 24'h0;
  end
  // one shared select rise starts every converter at once
  task start;
    begin
      @(negedge mclk_i) cs_n_o = 1'b0;
      repeat (8) @(negedge mclk_i);
      cs_n_o = 1'b1;
    end
  endtask
  // n falls at a 160 ns period with one long pause mid-word; sample before each fall
  task read(input integer n);
    integer k;
    begin
      @(negedge mclk_i) cs_n_o = 1'b0;
      repeat (10) @(negedge mclk_i);
      for (k = 0; k < n; k = k + 1) begin
        repeat (k == 12 ? 20 : 4) @(negedge mclk_i);
        data_q[23-k] = line;
        sck_o = 1'b0;
        repeat (4) @(negedge mclk_i);
        sck_o = 1'b1;
      end
    end
  endtask
  task release_cs;
    @(negedge mclk_i) cs_n_o = 1'b1;
  endtask
endmodule // host_model

// >>> sim/adc_rate_and_sync_control_test.sv
// self-checking bench for the rate and sync control
`timescale 1ns/10ps
`define CHK(a, b) begin compares = compares + 1; if ((a) !== (b)) begin \
  err_count = err_count + 1; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module adc_rate_and_sync_control_test;
  localparam NCONV = 20;
  // ten notch-pin clocks make one modulator sample
  localparam NSAMP = NCONV / 10;
  reg         mclk_i, nrst_i, pin, ext_en, e_ext, e50;
  reg  [23:0] result_i;
  reg  [27:0] row [0:3];
  integer     i, ticks, err_count, compares;
  wire        cs_n, sck, sdo_o, sdo_oe_o, mod_sample_o, conv_busy_o, conv_done_o;
  wire        ext_clk_mode_o, notch50_o;
  // short conversion keeps the run brief
  adc_rate_and_sync_control #(.CONV_CLKS(NCONV)) adc_rate_and_sync_control_i (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .notch_select_clock_pin_i(pin), .cs_n_i(cs_n),
    .sck_i(sck), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .result_i(result_i),
    .mod_sample_o(mod_sample_o), .conv_busy_o(conv_busy_o), .conv_done_o(conv_done_o),
    .ext_clk_mode_o(ext_clk_mode_o), .notch50_o(notch50_o));
  host_model host_model_i (.mclk_i(mclk_i), .sdo_i(sdo_o), .sdo_oe_i(sdo_oe_o),
    .cs_n_o(cs_n), .sck_o(sck));
  // clock, external notch clock, modulator sample count
  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end
  initial forever begin
    #200;
    if (ext_en) pin = ~pin;
  end
  always @(posedge mclk_i) if (mod_sample_o === 1'b1) ticks = ticks + 1;
  task wait_done;
    integer n;
    begin
      n = 0;
      while (conv_done_o !== 1'b1 && n < 20000) begin
        @(negedge mclk_i);
        n = n + 1;
      end
      if (n >= 20000) err_count = err_count + 1;
      @(negedge mclk_i);
    end
  endtask
  task results;
    begin
      $display("compares %0d errors %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  // watchdog: the tests need about 50k clocks, so 80k means a hang
  initial begin
    #1600000;
    err_count = err_count + 1;
    results;
  end
  // rows: expected ext, expected 50 hz, ext clock, pin level, result
  initial begin
    row[0] = {4'b0000, 24'ha5f00f};
    row[1] = {4'b0101, 24'h5a0ff0};
    row[2] = {4'b1010, 24'hc3c3c3};
    row[3] = {4'b0000, 24'h123456};
    {nrst_i, pin, ext_en, ticks, err_count, compares, result_i} = 0;
    repeat (4) @(negedge mclk_i);
    `CHK(conv_busy_o, 1'b0)
    `CHK(sdo_oe_o, 1'b0)
    nrst_i = 1'b1;
    for (i = 0; i < 4; i = i + 1) begin
      {e_ext, e50, ext_en, pin, result_i} = row[i];
      repeat (1200) @(negedge mclk_i);
      ticks = 0;
      host_model_i.start;
      wait_done;
      `CHK(ticks, NSAMP)
      `CHK(ext_clk_mode_o, e_ext)
      if (!e_ext) `CHK(notch50_o, e50)
      host_model_i.read(23);
      `CHK(host_model_i.data_q[23:1], result_i[23:1])
    end
    // full read autostarts, short read waits for a select rise
    host_model_i.start;
    wait_done;
    host_model_i.read(24);
    `CHK(host_model_i.data_q, result_i)
    repeat (10) @(negedge mclk_i);
    `CHK(conv_busy_o, 1'b1)
    wait_done;
    host_model_i.read(23);
    `CHK(host_model_i.data_q[23:1], result_i[23:1])
    repeat (2000) @(negedge mclk_i);
    `CHK(conv_busy_o, 1'b0)
    host_model_i.release_cs;
    repeat (10) @(negedge mclk_i);
    `CHK(conv_busy_o, 1'b1)
    `CHK(sdo_oe_o, 1'b0)
    wait_done;
    // reset in mid-conversion: no start and no rate clock may follow it
    host_model_i.start;
    repeat (20) @(negedge mclk_i);
    nrst_i = 1'b0;
    repeat (2) @(negedge mclk_i);
    `CHK(conv_busy_o, 1'b0)
    nrst_i = 1'b1;
    repeat (20) @(negedge mclk_i);
    `CHK(conv_busy_o, 1'b0)
    `CHK(ext_clk_mode_o, 1'b0)
    results;
  end
endmodule // adc_rate_and_sync_control_test
